/* link_switch_config_control_tb.sv */
/*
  Self-checking bench for the link switch configuration bank.
  Assumes the host model for APB and straps driven from here.
*/
`timescale 1ns/1ps
`default_nettype none
module link_switch_config_control_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] rd;
  } lsc_row_s;

  logic               pclk, presetn, pready, pslverr, psel, penable, pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, r;
  logic               e;
  lsc_pkg::lsc_strap_s st;
  lsc_pkg::lsc_cfg_s   o;
  logic [6:0]         sa;
  logic               par;
  int                 mismatches, compares, cyc;
  lsc_row_s           rows [10];

  lsc_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

  lsc_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .source_select_straps(st.src),
    .global_boost_strap(st.boost), .output_drive_enable_strap(st.out_en),
    .output_term_strap(st.out_term), .output_current_strap(st.out_cur),
    .preemph_strap_bus(st.preemph), .slave_addr_straps(st.addr),
    .source_sel(o.src), .output_drive_enable_bit(o.out_en),
    .input_term_switch_bit(o.term), .input_boost_bit(o.boost),
    .output_term_bit(o.out_term), .output_current_bit(o.out_cur),
    .preemph_field(o.preemph), .slave_addr(sa), .parallel_active(par));

  // Clock and hang guard
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reset for 3 cycles, then past the strap load
  task automatic do_reset();
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (lsc_pkg::LOAD_CYC + 1) @(posedge pclk);
    #1;
  endtask

  // Outputs as loaded from straps and defaults
  task automatic check_straps();
    check("src", 32'(o.src), 32'(st.src));
    check("en", 32'(o.out_en), 32'(st.out_en));
    check("boost", 32'(o.boost), {24'h0, {8{st.boost}}});
    check("oterm", 32'(o.out_term), 32'(st.out_term));
    check("cur", 32'(o.out_cur), 32'(st.out_cur));
    check("pe", 32'(o.preemph), 32'(st.preemph));
    check("term", 32'(o.term), 32'(lsc_pkg::RST_TERM));
    check("sa", 32'(sa), 32'({lsc_pkg::ADDR_HI, st.addr}));
    check("par", 32'(par), 32'h1);
  endtask

  function automatic logic [31:0] obs(logic [7:0] a);
    case (a)
      lsc_pkg::SEL_OFF:   return 32'(o.src);
      lsc_pkg::MODE_OFF:  return 32'(o.out_en);
      lsc_pkg::TERM_OFF:  return 32'(o.term);
      lsc_pkg::BOOST_OFF: return 32'(o.boost);
      default:            return 32'({o.preemph, o.out_cur, o.out_term});
    endcase
  endfunction

  // Main sequence
  initial begin
    mismatches = 0;
    compares   = 0;
    cyc        = 0;
    presetn    = 1'h0;
    st         = 11'h0a5;
    rows = '{'{lsc_pkg::SEL_OFF, 32'hffffffff, 32'h3}, '{lsc_pkg::SEL_OFF, 32'h1, 32'h1},
      '{lsc_pkg::MODE_OFF, 32'hfffffffe, 32'h0}, '{lsc_pkg::MODE_OFF, 32'h1, 32'h1},
      '{lsc_pkg::TERM_OFF, 32'h1a5c3, 32'ha5c3}, '{lsc_pkg::BOOST_OFF, 32'h15a, 32'h5a},
      '{lsc_pkg::TX_OFF, 32'h3, 32'h3}, '{lsc_pkg::TX_OFF, 32'h6, 32'h6},
      '{lsc_pkg::TX_OFF, 32'hb, 32'hb}, '{lsc_pkg::TX_OFF, 32'hfc, 32'hc}};
    do_reset();
    check_straps();
    // Strap changes in parallel mode; select waits for reset
    @(posedge pclk);
    st.boost   <= 1'h1;
    st.preemph <= 2'h2;
    st.src     <= ~st.src;
    repeat (25) @(posedge pclk);
    #1;
    check("pboost", 32'(o.boost), 32'hff);
    check("ppe", 32'(o.preemph), 32'h2);
    check("psrc", 32'(o.src), 32'h0);
    // Any access after the strap load ends parallel mode
    host.xfer(1'h0, lsc_pkg::STAT_OFF, 32'h0, r, e);
    host.xfer(1'h0, lsc_pkg::STAT_OFF, 32'h0, r, e);
    check("stat", r, 32'({lsc_pkg::ADDR_HI, st.addr}) << 8);
    st.boost   <= 1'h0;
    st.out_en  <= ~st.out_en;
    repeat (25) @(posedge pclk);
    #1;
    check("sboost", 32'(o.boost), 32'hff);
    check("spar", 32'(par), 32'h0);
    check("sen", 32'(o.out_en), 32'h1);
    // Table: select, mode, terminations, boost and transmitter programmed separately
    foreach (rows[i]) begin
      host.xfer(1'h1, rows[i].a, rows[i].d, r, e);
      host.xfer(1'h0, rows[i].a, 32'h0, r, e);
      check("rd", r, rows[i].rd);
      repeat (12) @(posedge pclk);
      #1;
      check("out", obs(rows[i].a), rows[i].rd);
    end
    // Unmapped place and read-only status
    host.xfer(1'h1, 8'h18, 32'hffffffff, r, e);
    check("uerr", 32'(e), 32'h1);
    host.xfer(1'h0, 8'h18, 32'h0, r, e);
    check("urd", {r[31:1], e}, 32'h1);
    host.xfer(1'h1, lsc_pkg::STAT_OFF, 32'hffffffff, r, e);
    host.xfer(1'h0, lsc_pkg::STAT_OFF, 32'h0, r, e);
    check("ro", r, 32'({lsc_pkg::ADDR_HI, st.addr}) << 8);
    // Late write inside a window replaces without restart
    host.xfer(1'h1, lsc_pkg::BOOST_OFF, 32'h01, r, e);
    repeat (3) @(posedge pclk);
    host.xfer(1'h1, lsc_pkg::BOOST_OFF, 32'h02, r, e);
    repeat (2) @(posedge pclk);
    #1;
    check("win1", 32'(o.boost), 32'h01);
    repeat (6) @(posedge pclk);
    #1;
    check("win2", 32'(o.boost), 32'h02);
    // Second reset with new straps, select then updates
    @(posedge pclk);
    st <= 11'h35a;
    do_reset();
    check_straps();
    final_report();
  end
endmodule
`default_nettype wire

/* lsc_ctrl.sv */
/*
  Configuration register bank of a four-to-one video link switch.
  Assumes an APB master on pclk and asynchronous strap pins that are
  synchronised here before use.
*/
// The address map and register access over APB are this design's own decisions.
// Function
// - Route exactly one of four sources
// - All four pairs of a link alike
// - Eight selectable slave addresses
// - Reset reloads from straps and defaults
// - Any bus access after the strap load disables straps until reset
// - One termination bit per input pair
// - Input terminations open after reset
// - Straps never change input terminations
// - Per-channel boost bit, 6 or 12 dB
// - One strap sets all boost bits
// - Output termination by bit or strap
// - Output tristate by enable bit or strap
// - Reset loads output termination from strap
// - Reset loads output current from strap
// - Four preemphasis levels, field or straps
// - Writes take effect through non-restarting window
// - Slave address is 1001 plus straps
// Mode flag is registered on its own so every output leaves a flop
`timescale 1ns/1ps
`default_nettype none

module lsc_ctrl (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [1:0]                    source_select_straps,
  input  wire logic                          global_boost_strap,
  input  wire logic                          output_drive_enable_strap,
  input  wire logic                          output_term_strap,
  input  wire logic                          output_current_strap,
  input  wire logic [1:0]                    preemph_strap_bus,
  input  wire logic [2:0]                    slave_addr_straps,
  output logic      [1:0]                    source_sel,
  output logic                               output_drive_enable_bit,
  output logic      [lsc_pkg::NUM_TERM-1:0]  input_term_switch_bit,
  output logic      [lsc_pkg::NUM_BOOST-1:0] input_boost_bit,
  output logic                               output_term_bit,
  output logic                               output_current_bit,
  output logic      [1:0]                    preemph_field,
  output logic      [6:0]                    slave_addr,
  output logic                               parallel_active
);

  typedef struct packed {
    lsc_pkg::lsc_strap_s                          s1;
    lsc_pkg::lsc_strap_s                          s2;
    lsc_pkg::lsc_phase_e                          phase;
    lsc_pkg::lsc_cnt_t                            load;
    lsc_pkg::lsc_cfg_s                            cfg;
    lsc_pkg::lsc_cfg_s                            app;
    logic [lsc_pkg::NUM_GRP-1:0][lsc_pkg::WIN_W-1:0] win;
    logic [6:0]                                   addr;
    logic                                         rdy;
    logic                                         err;
    logic [31:0]                                  rdata;
    logic                                         par;
  } lsc_state_s;

  lsc_state_s s_r;
  lsc_state_s s_nxt;
  lsc_pkg::lsc_strap_s pins;
  logic acc_done;
  logic wr_done;

  // Register index from a byte address; 7 marks an unmapped address
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    case (a)
      lsc_pkg::SEL_OFF:   reg_idx = 3'h0;
      lsc_pkg::MODE_OFF:  reg_idx = 3'h1;
      lsc_pkg::TERM_OFF:  reg_idx = 3'h2;
      lsc_pkg::BOOST_OFF: reg_idx = 3'h3;
      lsc_pkg::TX_OFF:    reg_idx = 3'h4;
      lsc_pkg::STAT_OFF:  reg_idx = 3'h5;
      default:            reg_idx = 3'h7;
    endcase
  endfunction

  // Read word for a register; stored, not applied, values read back
  function automatic logic [31:0] rd_word(input logic [2:0] idx, input lsc_state_s st);
    rd_word = 32'h0000_0000;
    case (idx)
      3'h0: rd_word[1:0] = st.cfg.src;
      3'h1: rd_word[lsc_pkg::MODE_EN_BIT] = st.cfg.out_en;
      3'h2: rd_word[lsc_pkg::NUM_TERM-1:0] = st.cfg.term;
      3'h3: rd_word[lsc_pkg::NUM_BOOST-1:0] = st.cfg.boost;
      3'h4: begin
        rd_word[lsc_pkg::TX_TERM_BIT] = st.cfg.out_term;
        rd_word[lsc_pkg::TX_CUR_BIT] = st.cfg.out_cur;
        rd_word[lsc_pkg::PREEMPH_FIELD_LSB +: 2] = st.cfg.preemph;
      end
      3'h5: begin
        rd_word[lsc_pkg::STAT_PAR_BIT] = (st.phase != lsc_pkg::PH_SER);
        rd_word[lsc_pkg::STAT_ADDR_LSB +: 7] = st.addr;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction

  assign pins = '{src: source_select_straps, boost: global_boost_strap,
                  out_en: output_drive_enable_strap, out_term: output_term_strap,
                  out_cur: output_current_strap, preemph: preemph_strap_bus,
                  addr: slave_addr_straps};
  assign acc_done = psel && penable && s_r.rdy;
  assign wr_done  = acc_done && pwrite;

  // Next state: sync, phase, bus slave, configuration and update windows
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pins;
    s_nxt.s2 = s_r.s1;
    // Zero-wait slave: ready in every access phase
    s_nxt.rdy = psel && !penable;
    s_nxt.err = psel && !penable && (reg_idx(paddr) == 3'h7);
    s_nxt.rdata = (psel && !penable && !pwrite) ? rd_word(reg_idx(paddr), s_r) : 32'h0000_0000;
    case (s_r.phase)
      lsc_pkg::PH_LOAD: begin
        // Straps plus fixed defaults, applied at once without a window
        s_nxt.cfg.src = s_r.s2.src;
        s_nxt.cfg.out_en = s_r.s2.out_en;
        s_nxt.cfg.term = lsc_pkg::RST_TERM;
        s_nxt.cfg.boost = {lsc_pkg::NUM_BOOST{s_r.s2.boost}};
        s_nxt.cfg.out_term = s_r.s2.out_term;
        s_nxt.cfg.out_cur = s_r.s2.out_cur;
        s_nxt.cfg.preemph = s_r.s2.preemph;
        s_nxt.app = s_nxt.cfg;
        s_nxt.addr = {lsc_pkg::ADDR_HI, s_r.s2.addr};
        s_nxt.load = s_r.load + 2'd1;
        if (s_r.load == lsc_pkg::lsc_cnt_t'(lsc_pkg::LOAD_CYC - 1)) begin
          s_nxt.phase = lsc_pkg::PH_PAR;
        end
      end
      lsc_pkg::PH_PAR: begin
        // Straps follow live; select only moves at reset, terms never
        s_nxt.cfg.out_en = s_r.s2.out_en;
        s_nxt.cfg.boost = {lsc_pkg::NUM_BOOST{s_r.s2.boost}};
        s_nxt.cfg.out_term = s_r.s2.out_term;
        s_nxt.cfg.out_cur = s_r.s2.out_cur;
        s_nxt.cfg.preemph = s_r.s2.preemph;
        if (acc_done) begin
          s_nxt.phase = lsc_pkg::PH_SER;
          s_nxt.cfg = s_r.cfg;
        end
      end
      lsc_pkg::PH_SER: s_nxt.phase = lsc_pkg::PH_SER;
      default: s_nxt.phase = lsc_pkg::PH_LOAD;
    endcase
    // Mode flag follows the next phase, so the pin needs no decode
    s_nxt.par = (s_nxt.phase != lsc_pkg::PH_SER);
    // Bus writes own the registers from the first access on
    if (wr_done) begin
      case (reg_idx(paddr))
        3'h0: s_nxt.cfg.src = pwdata[1:0];
        3'h1: s_nxt.cfg.out_en = pwdata[lsc_pkg::MODE_EN_BIT];
        3'h2: s_nxt.cfg.term = pwdata[lsc_pkg::NUM_TERM-1:0];
        3'h3: s_nxt.cfg.boost = pwdata[lsc_pkg::NUM_BOOST-1:0];
        3'h4: begin
          s_nxt.cfg.out_term = pwdata[lsc_pkg::TX_TERM_BIT];
          s_nxt.cfg.out_cur = pwdata[lsc_pkg::TX_CUR_BIT];
          s_nxt.cfg.preemph = pwdata[lsc_pkg::PREEMPH_FIELD_LSB +: 2];
        end
        default: s_nxt.cfg = s_nxt.cfg;
      endcase
    end
    // Per-register window: a change outside it applies at once and opens
    // it; changes inside only update the pending value, applied at its end
    if (s_r.phase != lsc_pkg::PH_LOAD) begin
      for (int g = 0; g < lsc_pkg::NUM_GRP; g++) begin
        if (s_r.win[g] == lsc_pkg::lsc_win_t'(0)) begin
          if (((s_nxt.cfg ^ s_r.app) & lsc_pkg::GRP_MASK[g]) != 31'h0) begin
            s_nxt.app = (s_r.app & ~lsc_pkg::GRP_MASK[g]) |
                        (s_nxt.cfg & lsc_pkg::GRP_MASK[g]);
            s_nxt.win[g] = lsc_pkg::lsc_win_t'(lsc_pkg::UPD_CYC);
          end
        end else begin
          s_nxt.win[g] = s_r.win[g] - lsc_pkg::lsc_win_t'(1);
          if (s_r.win[g] == lsc_pkg::lsc_win_t'(1)) begin
            s_nxt.app = (s_nxt.app & ~lsc_pkg::GRP_MASK[g]) |
                        (s_nxt.cfg & lsc_pkg::GRP_MASK[g]);
          end
        end
      end
    end
  end

  // Whole state in one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Everything clears except the mode flag, which resets to parallel
      s_r     <= '0;
      s_r.par <= 1'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign source_sel              = s_r.app.src;
  assign output_drive_enable_bit = s_r.app.out_en;
  assign input_term_switch_bit   = s_r.app.term;
  assign input_boost_bit         = s_r.app.boost;
  assign output_term_bit         = s_r.app.out_term;
  assign output_current_bit      = s_r.app.out_cur;
  assign preemph_field           = s_r.app.preemph;
  assign slave_addr              = s_r.addr;
  assign parallel_active         = s_r.par;
  assign prdata                  = s_r.rdata;
  assign pready                  = s_r.rdy;
  assign pslverr                 = s_r.err;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  localparam int WIN_CYC = lsc_pkg::UPD_CYC;

  sequence term_wr_s;
    wr_done && (paddr == lsc_pkg::TERM_OFF);
  endsequence

  sequence term_win_open_s;
    term_wr_s ##0 (s_r.win[2] == lsc_pkg::lsc_win_t'(0)) ##0 (pwdata[15:0] != s_r.app.term);
  endsequence

  // First cycle of parallel mode, right after the strap load
  sequence load_done_s;
    (s_r.phase == lsc_pkg::PH_PAR) && ($past(s_r.phase) == lsc_pkg::PH_LOAD);
  endsequence

  // Parallel mode, its exit and the fixed slave address pattern

  term_open_a: assert property (s_r.phase != lsc_pkg::PH_SER |-> input_term_switch_bit == 16'h0000)
    else $error("input terminations closed without bus write");
  term_par_a: assert property (s_r.phase == lsc_pkg::PH_PAR && !acc_done |=>
      $stable(input_term_switch_bit))
    else $error("straps altered input terminations");
  ser_sticky_a: assert property (!parallel_active |=> !parallel_active)
    else $error("parallel mode returned without reset");
  ser_entry_a: assert property (acc_done && s_r.phase == lsc_pkg::PH_PAR |=> !parallel_active)
    else $error("bus access left parallel mode active");
  addr_fix_a: assert property (s_r.phase != lsc_pkg::PH_LOAD |-> slave_addr[6:3] == 4'h9)
    else $error("slave address upper pattern wrong");
  boost_par_a: assert property (s_r.phase == lsc_pkg::PH_PAR &&
      $past(s_r.phase) == lsc_pkg::PH_PAR |-> s_r.cfg.boost == {8{$past(s_r.s2.boost)}})
    else $error("boost strap not copied to all channels");
  // Window timing on the termination register
  win_imm_a: assert property (term_win_open_s |=>
      input_term_switch_bit == $past(pwdata[15:0]) ##1 $stable(input_term_switch_bit)[*3])
    else $error("write outside window not applied at once");
  win_end_a: assert property (s_r.win[2] == lsc_pkg::lsc_win_t'(1) |=> input_term_switch_bit == s_r.cfg.term)
    else $error("pending terminations not applied at window end");
  win_hold_a: assert property (term_win_open_s |=> (s_r.win[2] != '0) [*1] ##[1:WIN_CYC] s_r.win[2] == '0)
    else $error("update window did not close in time");
  // Strap load at the end of reset
  load_tx_a: assert property (load_done_s |->
      output_term_bit == $past(s_r.s2.out_term) && output_current_bit == $past(s_r.s2.out_cur))
    else $error("output settings not loaded from straps");
  src_load_a: assert property (load_done_s |->
      source_sel == $past(s_r.s2.src) && output_drive_enable_bit == $past(s_r.s2.out_en))
    else $error("select or drive enable not loaded from straps");
  pe_load_a: assert property (load_done_s |->
      preemph_field == $past(s_r.s2.preemph) && input_boost_bit == {8{$past(s_r.s2.boost)}})
    else $error("preemphasis or boost not loaded from straps");
  addr_low_a: assert property (load_done_s |-> slave_addr[2:0] == $past(s_r.s2.addr))
    else $error("slave address low bits not from straps");

  // Straps in parallel mode: select frozen, boost always uniform
  src_hold_a: assert property (s_r.phase == lsc_pkg::PH_PAR && !acc_done |=>
      $stable(source_sel))
    else $error("select moved without reset");
  boost_all_a: assert property (parallel_active |->
      input_boost_bit == {8{input_boost_bit[0]}})
    else $error("boost bits differ in parallel mode");

  // Writes with an idle window reach the pins one cycle later; a busy
  // window is covered by the pending path check above for terminations only
  src_wr_a: assert property (wr_done && paddr == lsc_pkg::SEL_OFF &&
      s_r.win[0] == '0 && s_r.phase != lsc_pkg::PH_LOAD
      |=> source_sel == $past(pwdata[1:0]))
    else $error("source select write not applied");
  en_wr_a: assert property (wr_done && paddr == lsc_pkg::MODE_OFF &&
      s_r.win[1] == '0 && s_r.phase != lsc_pkg::PH_LOAD
      |=> output_drive_enable_bit == $past(pwdata[lsc_pkg::MODE_EN_BIT]))
    else $error("drive enable write not applied");
  boost_wr_a: assert property (wr_done && paddr == lsc_pkg::BOOST_OFF &&
      s_r.win[3] == '0 && s_r.phase != lsc_pkg::PH_LOAD
      |=> input_boost_bit == $past(pwdata[7:0]))
    else $error("boost write not applied");
  tx_wr_a: assert property (wr_done && paddr == lsc_pkg::TX_OFF &&
      s_r.win[4] == '0 && s_r.phase != lsc_pkg::PH_LOAD
      |=> {preemph_field, output_current_bit, output_term_bit} == $past(pwdata[3:0]))
    else $error("transmitter settings write not applied");

endmodule

`default_nettype wire

/* lsc_host.sv */
/*
  APB host model standing in for the switch's controller.
  Assumes pclk from the bench; waits on pready with no fixed latency.
*/
`timescale 1ns/1ps
`default_nettype none
module lsc_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic [7:0]  paddr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] pwdata
);
  // Idle bus from time zero
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer, request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    pwdata  <= ~d;  // Released data must not look valid
  endtask
endmodule
`default_nettype wire

/* lsc_pkg.sv */
/*
  Shared constants and types for the link switch configuration block:
  register offsets, field positions, reset values, timing and carriers.
  Assumes a 200 MHz register clock and a 32-bit APB register bus.
*/
`default_nettype none

package lsc_pkg;

  // Geometry
  localparam int NUM_SRC   = 4;
  localparam int NUM_TERM  = 16;  // Four sources, four pairs each
  localparam int NUM_BOOST = 8;
  localparam int NUM_GRP   = 5;   // One update window per writable register

  // Register byte offsets
  localparam logic [7:0] SEL_OFF   = 8'h00;
  localparam logic [7:0] MODE_OFF  = 8'h04;
  localparam logic [7:0] TERM_OFF  = 8'h08;
  localparam logic [7:0] BOOST_OFF = 8'h0c;
  localparam logic [7:0] TX_OFF    = 8'h10;
  localparam logic [7:0] STAT_OFF  = 8'h14;

  // Field positions
  localparam int MODE_EN_BIT   = 0;
  localparam int TX_TERM_BIT   = 0;
  localparam int TX_CUR_BIT    = 1;
  localparam int PREEMPH_FIELD_LSB     = 2;
  localparam int STAT_PAR_BIT  = 0;
  localparam int STAT_ADDR_LSB = 8;

  // Reset values and fixed patterns
  localparam logic [15:0] RST_TERM = 16'h0000;
  localparam logic [3:0]  ADDR_HI  = 4'h9;

  // Update window, least time rounded up to whole cycles
  localparam int UPD_DELAY_NS = 50;
  localparam int CLK_PS       = 5000;
  localparam int UPD_CYC      = (UPD_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WIN_W        = $clog2(UPD_CYC + 1);
  localparam int LOAD_CYC     = 3;  // Strap synchroniser depth plus one

  typedef logic [WIN_W-1:0] lsc_win_t;
  typedef logic [1:0]       lsc_cnt_t;

  // Configuration carrier; masks below follow this bit order
  typedef struct packed {
    logic [1:0]           src;
    logic                 out_en;
    logic [NUM_TERM-1:0]  term;
    logic [NUM_BOOST-1:0] boost;
    logic                 out_term;
    logic                 out_cur;
    logic [1:0]           preemph;
  } lsc_cfg_s;

  localparam logic [NUM_GRP-1:0][30:0] GRP_MASK = {
    31'h0000_000f,   // Transmitter settings
    31'h0000_0ff0,   // Equalizer boost
    31'h0fff_f000,   // Input terminations
    31'h1000_0000,   // Device modes
    31'h6000_0000    // Source select
  };

  // Strap pin carrier
  typedef struct packed {
    logic [1:0] src;
    logic       boost;
    logic       out_en;
    logic       out_term;
    logic       out_cur;
    logic [1:0] preemph;
    logic [2:0] addr;
  } lsc_strap_s;

  typedef enum logic [1:0] {PH_LOAD, PH_PAR, PH_SER} lsc_phase_e;

endpackage

`default_nettype wire
